//--- rtl/ctp_regs.svh
// Purpose: register map, field positions and framing constants of the correction table parser
// Assumes: included by bare name wherever the numbers are needed
// Notes: byte addresses on a 32-bit APB bus, one word per register
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define CTP_OFS_CTRL 12'h000
`define CTP_OFS_PID 12'h004
`define CTP_OFS_GROUP 12'h008
`define CTP_OFS_SESSION 12'h00c
`define CTP_OFS_STATUS 12'h010
`define CTP_OFS_TIME 12'h014
`define CTP_OFS_POWER 12'h018
`define CTP_OFS_FREQ 12'h01c
`define CTP_OFS_NLI_LEN 12'h020
`define CTP_OFS_NLI_IDX 12'h024
`define CTP_OFS_NLI_DATA 12'h028

// ****************************************
// register fields and reset values
// ****************************************
`define CTP_CTRL_EN 0
`define CTP_CTRL_MODE 1
`define CTP_ST_CRC_ERR 0
`define CTP_ST_OVERRUN 1
`define CTP_ST_CORR 2
`define CTP_ST_NLI 3
`define CTP_ST_CLS_LO 4
`define CTP_ST_CLS_HI 5
`define CTP_PWR_SEL 7
`define CTP_PWR_CAT_LO 8
`define CTP_PWR_CAT_HI 9
`define CTP_PWR_PRES 10
`define CTP_TIME_PRES 16
`define CTP_FREQ_PRES 16
`define CTP_PID_RST 13'h0000
`define CTP_GROUP_RST 8'h00
`define CTP_SESSION_RST 16'h0000

// ****************************************
// section framing
// ****************************************
`define CTP_TBL_HDR_LAST 12'h007
`define CTP_TIM_HDR_LAST 12'h00c
`define CTP_LEN_HI_IDX 12'h001
`define CTP_LEN_LO_IDX 12'h002
`define CTP_PRE_LEN_BYTES 12'h003
`define CTP_CRC_BYTES 12'h004
`define CTP_F_TIME 7
`define CTP_F_POW 6
`define CTP_F_FREQ 5
`define CTP_F_CAT_HI 4
`define CTP_F_CAT_LO 3
`define CTP_F_SCALE_HI 2
`define CTP_CRC_POLY 32'h04c11db7
`define CTP_CRC_INIT 32'hffffffff

// ****************************************
// descriptor tags
// ****************************************
`define CTP_TAG_NLI 8'ha0
`define CTP_TAG_STD_LO 8'ha0
`define CTP_TAG_STD_HI 8'hb6
`define CTP_TAG_RSV 8'hb4
`define CTP_TAG_LINKAGE 8'h4a
`define CTP_TAG_USER_LO 8'he0
`define CTP_TAG_USER_HI 8'hfe
`define CTP_NLI_MAX 9'h0ff

`endif

//--- rtl/ctp_pkg.sv
// Purpose: shared types of the correction table parser
// Assumes: nothing beyond the header of constants
// Notes: enum order follows the wire encoding
package ctp_pkg;
	typedef enum logic [1:0] {
		cat_traffic_burst,
		cat_common_signalling_burst,
		cat_acquisition_burst,
		cat_synchronisation_burst
	} ctp_cat_e;

	typedef enum logic [1:0] {
		cls_reserved,
		cls_standard,
		cls_user_defined
	} ctp_cls_e;
endpackage

//--- rtl/ctp_byte_if.sv
// Purpose: accepted section bytes shared by the parser, checksum and tag classifier
// Assumes: one clock domain
// Notes: first marks byte 0 of a section
interface ctp_byte_if;
	import ctp_pkg::*;
	logic [7:0] data;
	logic valid;
	logic first;
	logic [31:0] crc;
	ctp_cls_e cls;
	modport parser (output data, output valid, output first, input crc, input cls);
	modport crc_end (input data, input valid, input first, output crc);
	modport tag_end (input data, output cls);
endinterface

//--- rtl/ctp_crc32.sv
// Purpose: running 32-bit section checksum, msb first, all-ones start
// Assumes: restarted by the first byte of each section
// Notes: crc reads zero after the trailing checksum bytes of a good section
`include "ctp_regs.svh"
module ctp_crc32 (
	input wire logic clk_i,
	input wire logic rst_i,
	ctp_byte_if.crc_end bif
);
	import ctp_pkg::*;
	logic [31:0] crc_r;
	logic [31:0] stage [0:8];

	assign stage[0] = bif.first ? `CTP_CRC_INIT : crc_r;

	// one xor stage per bit of the byte
	for (genvar i = 0; i < 8; i++) begin : g_bit
		assign stage[i + 1] = {stage[i][30:0], 1'b0} ^
			((stage[i][31] ^ bif.data[7 - i]) ? `CTP_CRC_POLY : 32'h0000_0000);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc_r <= `CTP_CRC_INIT;
		end else if (bif.valid) begin
			crc_r <= stage[8];
		end
	end

	assign bif.crc = crc_r;
endmodule

//--- rtl/ctp_tag_class.sv
// Purpose: classify a descriptor tag byte
// Assumes: data is the tag byte when the parser samples cls
// Notes: purely combinational
`include "ctp_regs.svh"
module ctp_tag_class (
	ctp_byte_if.tag_end bif
);
	import ctp_pkg::*;

	always_comb begin
		if (bif.data >= `CTP_TAG_USER_LO && bif.data <= `CTP_TAG_USER_HI) begin
			bif.cls = cls_user_defined;
		end else if (bif.data == `CTP_TAG_LINKAGE) begin
			bif.cls = cls_standard;
		end else if (bif.data >= `CTP_TAG_STD_LO && bif.data <= `CTP_TAG_STD_HI && bif.data != `CTP_TAG_RSV) begin
			bif.cls = cls_standard;
		end else begin
			bif.cls = cls_reserved;
		end
	end
endmodule

//--- rtl/ctp_parser.sv
// Purpose: parse correction feedback table sections and descriptor loops for this terminal
// Assumes: section bytes arrive in order from the demultiplexer on the system clock
// Notes: correction outputs and layer info length are only released after the section checksum passes; payload bytes are stored as they arrive

`include "ctp_regs.svh"

// Overview of operation
// - accept section bytes only from the programmed transport PID
// - first 64 bits of a table section are the private header
// - entry count plus one gives the number of entries
// - each entry opens with a group number compared with ours
// - a 16-bit session number follows, compared with ours
// - session numbers match in unscrambled form on both sides
// - timing byte present only when its flag is one
// - power flag brings selector bit then 7-bit power or measured snr
// - frequency flag brings a 16-bit final field
// - entry fields decode like the unicast correction descriptor
// - entry length comes only from presence flags
// - checksum over whole section must leave a zero remainder
// - descriptors open with a tag byte naming the type
// - length byte counts the body and bounds the skip
// - tags e0 to fe are user-defined extensions
// - layer info payload is at most 255 bytes
// - layer info payload is passed on untouched
// - burst category 00 traffic, 01 signalling, 10 acquisition, 11 sync
// - timing shifted by exponent, vacated bits one then zeros
// - scaled timing counts 27 MHz reference clock cycles
// - frequency in 10 Hz steps, negative lowers the carrier
module ctp_parser (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [7:0] sec_byte_i,
	input wire logic sec_valid_i,
	input wire logic sec_start_i,
	input wire logic [12:0] sec_pid_i,
	output logic corr_valid_o,
	output logic corr_time_present_o,
	output logic [15:0] corr_time_o,
	output logic corr_power_present_o,
	output logic corr_power_sel_o,
	output logic [6:0] corr_power_o,
	output logic corr_freq_present_o,
	output logic [15:0] corr_freq_o,
	output ctp_pkg::ctp_cat_e corr_cat_o,
	output logic nli_valid_o,
	output logic sec_error_o
);
	import ctp_pkg::*;

	typedef enum {
		st_idle, st_hdr, st_count, st_grp, st_ses_h, st_ses_l, st_flags, st_time, st_power,
		st_freq_h, st_freq_l, st_d_tag, st_d_len, st_d_body, st_tail, st_check, st_drop
	} ctp_state_e;

	ctp_state_e state_r;
	logic ctrl_en_r, ctrl_mode_r, sec_mode_r;
	logic [12:0] pid_r;
	logic [7:0] group_r;
	logic [15:0] session_r;
	logic [11:0] bidx_r, sec_len_r;
	logic [8:0] left_r;
	logic [7:0] flags_r, time_r, pow_r, ses_hi_r, freq_hi_r, tag_r, dcnt_r;
	logic grp_hit_r, ses_hit_r;
	logic pend_valid_r;
	logic [7:0] pend_flags_r, pend_time_r, pend_pow_r;
	logic [15:0] pend_freq_r;
	logic nli_pend_r;
	logic [7:0] nli_wptr_r, nli_pend_len_r, nli_len_r, nli_idx_r;
	logic [7:0] nli_mem [0:254];
	ctp_cls_e last_cls_r;
	logic st_crc_r, st_ovr_r, st_corr_r, st_nli_r;
	logic [31:0] prdata_r;
	logic acc, first, in_body, field_st, entry_end, desc_end, crc_ok;
	logic ev_ovr, ev_ok, ev_bad;
	logic [7:0] fl;
	logic [11:0] hdr_last;
	ctp_state_e entry_nxt;
	logic apb_wr, apb_setup, addr_ok;

	ctp_byte_if bif ();

	// ****************************************
	// byte acceptance and helpers
	// ****************************************
	assign acc = sec_valid_i && ctrl_en_r && (sec_pid_i == pid_r);
	assign first = acc && sec_start_i;
	assign bif.data = sec_byte_i;
	assign bif.valid = acc;
	assign bif.first = first;
	assign crc_ok = (bif.crc == 32'h0000_0000);
	// body ends where the four checksum bytes begin
	assign in_body = (bidx_r + `CTP_CRC_BYTES) < (sec_len_r + `CTP_PRE_LEN_BYTES);
	assign hdr_last = sec_mode_r ? `CTP_TIM_HDR_LAST : `CTP_TBL_HDR_LAST;

	ctp_crc32 u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bif(bif)
	);

	ctp_tag_class u_tag (
		.bif(bif)
	);

	always_comb begin
		field_st = (state_r inside {st_count, st_grp, st_ses_h, st_ses_l, st_flags, st_time, st_power,
			st_freq_h, st_freq_l, st_d_tag, st_d_len, st_d_body});
	end

	// entry length follows from the flags alone, no tag or length bytes
	always_comb begin
		fl = (state_r == st_flags) ? sec_byte_i : flags_r;
		entry_nxt = st_idle;
		case (state_r)
			st_flags: begin
				entry_nxt = fl[`CTP_F_TIME] ? st_time : fl[`CTP_F_POW] ? st_power :
					fl[`CTP_F_FREQ] ? st_freq_h : st_idle;
			end
			st_time: begin
				entry_nxt = fl[`CTP_F_POW] ? st_power : fl[`CTP_F_FREQ] ? st_freq_h : st_idle;
			end
			st_power: begin
				entry_nxt = fl[`CTP_F_FREQ] ? st_freq_h : st_idle;
			end
			st_freq_h: begin
				entry_nxt = st_freq_l;
			end
			default: begin
				entry_nxt = st_idle;
			end
		endcase
		entry_end = acc && !first && in_body && entry_nxt == st_idle &&
			(state_r inside {st_flags, st_time, st_power, st_freq_l});
		desc_end = acc && !first && in_body && ((state_r == st_d_len && sec_byte_i == 8'h00) ||
			(state_r == st_d_body && dcnt_r == 8'h01));
	end

	assign ev_ovr = acc && !first && field_st && !in_body;
	assign ev_ok = (state_r == st_check) && crc_ok;
	assign ev_bad = (state_r == st_check) && !crc_ok;

	// ****************************************
	// section walk
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= st_idle;
			bidx_r <= 12'h000;
			sec_len_r <= 12'h000;
			sec_mode_r <= 1'b0;
			left_r <= 9'h000;
		end else if (first) begin
			state_r <= st_hdr;
			bidx_r <= 12'h001;
			sec_mode_r <= ctrl_mode_r;
		end else if (state_r == st_check) begin
			state_r <= st_idle;
		end else if (ev_ovr) begin
			state_r <= st_drop;
		end else if (acc) begin
			bidx_r <= bidx_r + 12'h001;
			case (state_r)
				st_hdr: begin
					if (bidx_r == `CTP_LEN_HI_IDX) begin
						sec_len_r[11:8] <= sec_byte_i[3:0];
					end
					if (bidx_r == `CTP_LEN_LO_IDX) begin
						sec_len_r[7:0] <= sec_byte_i;
					end
					if (bidx_r == hdr_last) begin
						state_r <= st_count;
					end
				end
				st_count: begin
					left_r <= {1'b0, sec_byte_i} + 9'h001;
					state_r <= sec_mode_r ? st_d_tag : st_grp;
				end
				st_grp: state_r <= st_ses_h;
				st_ses_h: state_r <= st_ses_l;
				st_ses_l: state_r <= st_flags;
				st_flags, st_time, st_power, st_freq_h, st_freq_l: begin
					if (entry_end) begin
						left_r <= left_r - 9'h001;
						state_r <= (left_r == 9'h001) ? st_tail : st_grp;
					end else begin
						state_r <= entry_nxt;
					end
				end
				st_d_tag: state_r <= st_d_len;
				st_d_len, st_d_body: begin
					if (desc_end) begin
						left_r <= left_r - 9'h001;
						state_r <= (left_r == 9'h001) ? st_tail : st_d_tag;
					end else begin
						state_r <= st_d_body;
					end
				end
				st_tail: begin
					// pad bytes before the checksum are absorbed here
					if (bidx_r == sec_len_r + `CTP_CRC_BYTES - 12'h002) begin
						state_r <= st_check;
					end
				end
				default: state_r <= state_r;
			endcase
		end
	end

	// ****************************************
	// entry fields and matching
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= 8'h00;
			time_r <= 8'h00;
			pow_r <= 8'h00;
			ses_hi_r <= 8'h00;
			freq_hi_r <= 8'h00;
			grp_hit_r <= 1'b0;
			ses_hit_r <= 1'b0;
		end else if (acc && !first && in_body) begin
			case (state_r)
				st_grp: grp_hit_r <= (sec_byte_i == group_r);
				st_ses_h: ses_hi_r <= sec_byte_i;
				// both numbers are compared unscrambled
				st_ses_l: ses_hit_r <= ({ses_hi_r, sec_byte_i} == session_r);
				st_flags: begin
					flags_r <= sec_byte_i;
					time_r <= 8'h00;
					pow_r <= 8'h00;
				end
				st_time: time_r <= sec_byte_i;
				st_power: pow_r <= sec_byte_i;
				st_freq_h: freq_hi_r <= sec_byte_i;
				default: flags_r <= flags_r;
			endcase
		end
	end

	// a later matching entry in the same section replaces an earlier one
	always_ff @(posedge clk_i) begin
		if (rst_i || first) begin
			pend_valid_r <= 1'b0;
			pend_flags_r <= 8'h00;
			pend_time_r <= 8'h00;
			pend_pow_r <= 8'h00;
			pend_freq_r <= 16'h0000;
		end else if (entry_end && grp_hit_r && ses_hit_r) begin
			pend_valid_r <= 1'b1;
			pend_flags_r <= fl;
			pend_time_r <= (state_r == st_time) ? sec_byte_i : time_r;
			pend_pow_r <= (state_r == st_power) ? sec_byte_i : pow_r;
			pend_freq_r <= (state_r == st_freq_l) ? {freq_hi_r, sec_byte_i} : 16'h0000;
		end
	end

	// ****************************************
	// descriptor loop and layer info payload
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || first) begin
			tag_r <= 8'h00;
			dcnt_r <= 8'h00;
			nli_wptr_r <= 8'h00;
			nli_pend_r <= 1'b0;
			nli_pend_len_r <= 8'h00;
		end else if (acc && in_body) begin
			case (state_r)
				st_d_tag: begin
					tag_r <= sec_byte_i;
				end
				st_d_len: begin
					dcnt_r <= sec_byte_i;
					if (tag_r == `CTP_TAG_NLI) begin
						nli_wptr_r <= 8'h00;
						nli_pend_r <= 1'b1;
						nli_pend_len_r <= sec_byte_i;
					end
				end
				st_d_body: begin
					dcnt_r <= dcnt_r - 8'h01;
					// the 8-bit pointer stops at the last slot of 255
					if (tag_r == `CTP_TAG_NLI && {1'b0, nli_wptr_r} < `CTP_NLI_MAX - 9'h001) begin
						nli_wptr_r <= nli_wptr_r + 8'h01;
					end
				end
				default: tag_r <= tag_r;
			endcase
		end
	end

	// payload is stored byte for byte, never interpreted
	always_ff @(posedge clk_i) begin
		if (acc && !first && in_body && state_r == st_d_body && tag_r == `CTP_TAG_NLI) begin
			nli_mem[nli_wptr_r] <= sec_byte_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_cls_r <= cls_reserved;
		end else if (acc && !first && state_r == st_d_tag) begin
			last_cls_r <= bif.cls;
		end
	end

	// ****************************************
	// release of results
	// ****************************************
	function automatic logic [15:0] ctp_scale(input logic [7:0] raw, input logic [2:0] n);
		logic [15:0] v;
		v = {{8{raw[7]}}, raw} << n;
		if (n != 3'h0) begin
			v = v | (16'h0001 << (n - 3'h1));
		end
		return v;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			corr_valid_o <= 1'b0;
			corr_time_present_o <= 1'b0;
			corr_time_o <= 16'h0000;
			corr_power_present_o <= 1'b0;
			corr_power_sel_o <= 1'b0;
			corr_power_o <= 7'h00;
			corr_freq_present_o <= 1'b0;
			corr_freq_o <= 16'h0000;
			corr_cat_o <= cat_traffic_burst;
			nli_valid_o <= 1'b0;
			nli_len_r <= 8'h00;
			sec_error_o <= 1'b0;
		end else begin
			corr_valid_o <= ev_ok && pend_valid_r;
			nli_valid_o <= ev_ok && nli_pend_r;
			sec_error_o <= ev_bad || ev_ovr;
			if (ev_ok && pend_valid_r) begin
				corr_time_present_o <= pend_flags_r[`CTP_F_TIME];
				// counts of the 27 MHz reference clock
				corr_time_o <= ctp_scale(pend_time_r, pend_flags_r[`CTP_F_SCALE_HI:0]);
				corr_power_present_o <= pend_flags_r[`CTP_F_POW];
				corr_power_sel_o <= pend_pow_r[`CTP_PWR_SEL];
				corr_power_o <= pend_pow_r[6:0];
				corr_freq_present_o <= pend_flags_r[`CTP_F_FREQ];
				// signed 10 Hz steps, negative lowers the carrier
				corr_freq_o <= pend_freq_r;
				corr_cat_o <= ctp_cat_e'(pend_flags_r[`CTP_F_CAT_HI:`CTP_F_CAT_LO]);
			end
			if (ev_ok && nli_pend_r) begin
				nli_len_r <= nli_pend_len_r;
			end
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	assign apb_setup = psel_i && !penable_i;
	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i <= `CTP_OFS_NLI_DATA);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_ok;
	assign prdata_o = prdata_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_en_r <= 1'b0;
			ctrl_mode_r <= 1'b0;
			pid_r <= `CTP_PID_RST;
			group_r <= `CTP_GROUP_RST;
			session_r <= `CTP_SESSION_RST;
			nli_idx_r <= 8'h00;
		end else if (apb_wr) begin
			case (paddr_i)
				`CTP_OFS_CTRL: begin
					ctrl_en_r <= pwdata_i[`CTP_CTRL_EN];
					ctrl_mode_r <= pwdata_i[`CTP_CTRL_MODE];
				end
				`CTP_OFS_PID: pid_r <= pwdata_i[12:0];
				`CTP_OFS_GROUP: group_r <= pwdata_i[7:0];
				`CTP_OFS_SESSION: session_r <= pwdata_i[15:0];
				`CTP_OFS_NLI_IDX: nli_idx_r <= pwdata_i[7:0];
				default: nli_idx_r <= nli_idx_r;
			endcase
		end
	end

	// sticky flags, write one to clear, a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_crc_r <= 1'b0;
			st_ovr_r <= 1'b0;
			st_corr_r <= 1'b0;
			st_nli_r <= 1'b0;
		end else begin
			st_crc_r <= ev_bad || (st_crc_r && !(apb_wr && paddr_i == `CTP_OFS_STATUS &&
				pwdata_i[`CTP_ST_CRC_ERR]));
			st_ovr_r <= ev_ovr || (st_ovr_r && !(apb_wr && paddr_i == `CTP_OFS_STATUS &&
				pwdata_i[`CTP_ST_OVERRUN]));
			st_corr_r <= (ev_ok && pend_valid_r) || (st_corr_r && !(apb_wr && paddr_i == `CTP_OFS_STATUS &&
				pwdata_i[`CTP_ST_CORR]));
			st_nli_r <= (ev_ok && nli_pend_r) || (st_nli_r && !(apb_wr && paddr_i == `CTP_OFS_STATUS &&
				pwdata_i[`CTP_ST_NLI]));
		end
	end

	// read data is fetched in the setup cycle so it comes from a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_r <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_r <= 32'h0000_0000;
			case (paddr_i)
				`CTP_OFS_CTRL: begin
					prdata_r[`CTP_CTRL_EN] <= ctrl_en_r;
					prdata_r[`CTP_CTRL_MODE] <= ctrl_mode_r;
				end
				`CTP_OFS_PID: prdata_r[12:0] <= pid_r;
				`CTP_OFS_GROUP: prdata_r[7:0] <= group_r;
				`CTP_OFS_SESSION: prdata_r[15:0] <= session_r;
				`CTP_OFS_STATUS: begin
					prdata_r[`CTP_ST_CRC_ERR] <= st_crc_r;
					prdata_r[`CTP_ST_OVERRUN] <= st_ovr_r;
					prdata_r[`CTP_ST_CORR] <= st_corr_r;
					prdata_r[`CTP_ST_NLI] <= st_nli_r;
					prdata_r[`CTP_ST_CLS_HI:`CTP_ST_CLS_LO] <= last_cls_r;
				end
				`CTP_OFS_TIME: begin
					prdata_r[15:0] <= corr_time_o;
					prdata_r[`CTP_TIME_PRES] <= corr_time_present_o;
				end
				`CTP_OFS_POWER: begin
					prdata_r[6:0] <= corr_power_o;
					prdata_r[`CTP_PWR_SEL] <= corr_power_sel_o;
					prdata_r[`CTP_PWR_CAT_HI:`CTP_PWR_CAT_LO] <= corr_cat_o;
					prdata_r[`CTP_PWR_PRES] <= corr_power_present_o;
				end
				`CTP_OFS_FREQ: begin
					prdata_r[15:0] <= corr_freq_o;
					prdata_r[`CTP_FREQ_PRES] <= corr_freq_present_o;
				end
				`CTP_OFS_NLI_LEN: prdata_r[7:0] <= nli_len_r;
				`CTP_OFS_NLI_IDX: prdata_r[7:0] <= nli_idx_r;
				`CTP_OFS_NLI_DATA: begin
					if ({1'b0, nli_idx_r} < `CTP_NLI_MAX) begin
						prdata_r[7:0] <= nli_mem[nli_idx_r];
					end
				end
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end
endmodule

//--- verif/ctp_parser_props.sv
// Purpose: port checks of the correction table parser
// Assumes: bound to ctp_parser, one clock domain
// Notes: sees the top module ports only
module ctp_parser_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [11:0] paddr_i,
	input wire logic pslverr_o,
	input wire logic sec_valid_i,
	input wire logic corr_valid_o,
	input wire logic corr_freq_present_o,
	input wire logic [15:0] corr_freq_o,
	input wire logic nli_valid_o,
	input wire logic sec_error_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ********************
	// properties
	// ********************
	sequence s_access;
		psel_i && penable_i;
	endsequence
	sequence s_release;
		corr_valid_o ##1 !corr_valid_o;
	endsequence
	chk_bad_addr: assert property (s_access ##0 (paddr_i[1:0] != 2'h0 || paddr_i > 12'h028) |-> pslverr_o)
		else $error("bad address not refused");
	chk_good_addr: assert property (s_access ##0 (paddr_i[1:0] == 2'h0 && paddr_i <= 12'h028) |-> !pslverr_o)
		else $error("good address refused");
	chk_corr_pulse: assert property (corr_valid_o |-> s_release)
		else $error("correction release not a single pulse");
	chk_corr_cause: assert property (corr_valid_o |-> $past(sec_valid_i, 2))
		else $error("correction release without a closing byte");
	chk_err_pulse: assert property (sec_error_o |=> !sec_error_o)
		else $error("error event not a single pulse");
	chk_err_discard: assert property (sec_error_o |-> !corr_valid_o && !nli_valid_o)
		else $error("release together with an error");
	chk_freq_absent: assert property (corr_valid_o && !corr_freq_present_o |-> corr_freq_o == 16'h0000)
		else $error("absent frequency not zero");
	chk_nli_pulse: assert property (nli_valid_o |=> !nli_valid_o)
		else $error("layer info release not a single pulse");
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !corr_valid_o && !nli_valid_o && !sec_error_o)
		else $error("event during reset");
endmodule

bind ctp_parser ctp_parser_props u_ctp_parser_props (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o), .sec_valid_i(sec_valid_i),
	.corr_valid_o(corr_valid_o), .corr_freq_present_o(corr_freq_present_o), .corr_freq_o(corr_freq_o),
	.nli_valid_o(nli_valid_o), .sec_error_o(sec_error_o));

//--- verif/ctp_ncc_model.sv
// Purpose: network side, sends sections through the demultiplexer
// Assumes: caller fills q with the section less its checksum
// Notes: length bytes and checksum are filled in here
module ctp_ncc_model (
	input wire logic clk_i,
	output logic [7:0] sec_byte_o,
	output logic sec_valid_o,
	output logic sec_start_o,
	output logic [12:0] sec_pid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	logic bad = 1'b0;
	logic busy = 1'b0;
	// ********************
	// byte stream
	// ********************
	initial begin
		sec_byte_o = 8'h00;
		sec_valid_o = 1'b0;
		sec_start_o = 1'b0;
		sec_pid_o = 13'h0000;
	end
	// idle byte line keeps changing so stale data never looks valid
	always @(posedge clk_i) if (!busy) sec_byte_o <= ~sec_byte_o;
	function automatic logic [31:0] crc_of(input int n);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < n; i++)
			for (int b = 7; b >= 0; b--)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ q[i][b]) ? 32'h04c11db7 : 32'h00000000);
		return c;
	endfunction
	task automatic send(input logic [12:0] pid);
		logic [31:0] c;
		int n;
		n = q.size() + 1;
		q[1] = {4'hb, n[11:8]};
		q[2] = n[7:0];
		c = crc_of(q.size()) ^ {31'h00000000, bad};
		for (int i = 3; i >= 0; i--)
			q.push_back(c[8*i +: 8]);
		busy = 1'b1;
		foreach (q[i]) begin
			@(posedge clk_i);
			sec_byte_o <= q[i];
			sec_valid_o <= 1'b1;
			sec_start_o <= (i == 0);
			sec_pid_o <= pid;
		end
		@(posedge clk_i);
		sec_valid_o <= 1'b0;
		sec_start_o <= 1'b0;
		busy = 1'b0;
		q = {};
	endtask
endmodule

//--- verif/ctp_parser_tb.sv
// Purpose: self-checking bench of the correction table parser
// Assumes: zero wait APB slave, 40 MHz clock
// Notes: sections come from the network model
module ctp_parser_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, psel_i, penable_i, pwrite_i, er;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic pready_o, pslverr_o, sec_valid_i, sec_start_i, corr_valid_o, corr_time_present_o, corr_power_present_o;
	logic corr_power_sel_o, corr_freq_present_o, nli_valid_o, sec_error_o;
	logic [7:0] sec_byte_i;
	logic [12:0] sec_pid_i;
	logic [15:0] corr_time_o, corr_freq_o;
	logic [6:0] corr_power_o;
	logic [1:0] corr_cat_o;
	int n_mismatch = 0, samples_checked = 0, cyc = 0, n_corr = 0, n_nli = 0, n_err = 0;
	ctp_parser u_ctp_parser (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .sec_byte_i(sec_byte_i), .sec_valid_i(sec_valid_i), .sec_start_i(sec_start_i),
		.sec_pid_i(sec_pid_i), .corr_valid_o(corr_valid_o), .corr_time_present_o(corr_time_present_o),
		.corr_time_o(corr_time_o), .corr_power_present_o(corr_power_present_o), .corr_power_sel_o(corr_power_sel_o),
		.corr_power_o(corr_power_o), .corr_freq_present_o(corr_freq_present_o), .corr_freq_o(corr_freq_o),
		.corr_cat_o(corr_cat_o), .nli_valid_o(nli_valid_o), .sec_error_o(sec_error_o));
	ctp_ncc_model u_ctp_ncc_model (.clk_i(clk_i), .sec_byte_o(sec_byte_i), .sec_valid_o(sec_valid_i),
		.sec_start_o(sec_start_i), .sec_pid_o(sec_pid_i));
	// ********************
	// shared tasks
	// ********************
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		n_corr += corr_valid_o;
		n_nli += nli_valid_o;
		n_err += sec_error_o;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic pb(input logic [7:0] b);
		u_ctp_ncc_model.q.push_back(b);
	endtask
	task automatic hdr(input int n, input logic [7:0] cnt);
		repeat (n) pb(8'h00);
		pb(cnt);
	endtask
	task automatic pw(input logic [31:0] w);
		for (int i = 3; i >= 0; i--)
			pb(w[8*i +: 8]);
	endtask
	task automatic run(input logic [12:0] pid, input int ec, input int en, input int ee);
		int c, n, e;
		c = n_corr;
		n = n_nli;
		e = n_err;
		u_ctp_ncc_model.send(pid);
		repeat (4) @(posedge clk_i);
		check("corr events", ec, n_corr - c);
		check("nli events", en, n_nli - n);
		check("error events", ee, n_err - e);
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic t_regs();
		apb(1'b0, 12'h004, 32'h0);
		check("pid reset", 32'h0, rd);
		apb(1'b0, 12'h030, 32'h0);
		check("unmapped err", 32'h1, er);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h004, 32'h123);
		apb(1'b1, 12'h008, 32'h5);
		apb(1'b1, 12'h00c, 32'h1234);
		$display("regs done");
	endtask
	task automatic t_match();
		hdr(8, 8'h02);
		pw(32'h061234e0);
		pw(32'h11810010);
		pw(32'h05123500);
		pw(32'h051234f2);
		pw(32'hfefdff38);
		run(13'h123, 1, 0, 0);
		check("time", 32'hfffa, corr_time_o);
		check("presence", 32'hf, {corr_time_present_o, corr_power_present_o, corr_power_sel_o,
			corr_freq_present_o});
		check("power", 32'h7d, corr_power_o);
		check("freq", 32'hff38, corr_freq_o);
		check("cat", 32'h2, corr_cat_o);
		$display("match done");
	endtask
	task automatic t_faults();
		for (int k = 0; k < 3; k++) begin
			u_ctp_ncc_model.bad = (k == 0);
			hdr(8, {7'h00, k == 2});
			pw(32'h05123400);
			run(13'h123 + (k == 1), 0, 0, k != 1);
		end
		$display("faults done");
	endtask
	task automatic t_cats();
		for (int c = 0; c < 4; c++) begin
			hdr(8, 8'h00);
			pw({24'h051234, 3'h0, c[1:0], 3'h0});
			run(13'h123, 1, 0, 0);
			check("cat loop", c, corr_cat_o);
			check("no time", 32'h0, corr_time_present_o);
		end
		$display("cats done");
	endtask
	task automatic t_nli();
		apb(1'b1, 12'h000, 32'h3);
		hdr(13, 8'h05);
		pw(32'ha002aa55);
		pw(32'ha10100a2);
		pw(32'h00a400a9);
		pb(8'h00);
		pb(8'he5);
		pb(8'h00);
		run(13'h123, 0, 1, 0);
		apb(1'b0, 12'h020, 32'h0);
		check("nli len", 32'h2, rd);
		apb(1'b1, 12'h024, 32'h1);
		apb(1'b0, 12'h028, 32'h0);
		check("nli byte", 32'h55, rd);
		apb(1'b0, 12'h010, 32'h0);
		check("tag class", 32'h2, rd[5:4]);
		$display("nli done");
	endtask
	initial begin
		rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_match();
		t_faults();
		t_cats();
		t_nli();
		test_done();
	end
endmodule
